/* File: rtl/i2ccr_ctrl.v */
// Behaviour
// - interrupt requested only when enable and flag set
// - new state code sets interrupt flag
// - flag cleared only by software writing one
// - bit 6 turns bus function on
// - start request enters master, starts when free
// - master stop request cleared on stop detect
// - slave stop request returns to not-addressed
// - ack assert set: drive data low at ack
// - ack assert clear: leave data high at ack
// - stop request cleared while controller disabled
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "i2ccr_defs.vh"

module i2ccr_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        state_load,
  input  wire [4:0]  state_code,
  input  wire        stop_seen,
  input  wire        bus_free,
  input  wire        is_master,
  input  wire        byte_start,
  input  wire        ack_slot,
  output wire        controller_enable,
  output wire        start_request,
  output wire        end_transfer_request,
  output wire        send_start,
  output wire        send_stop,
  output wire        slave_release,
  output wire        sda_o,
  output wire        sda_oe,
  output wire        irq_ctrl,
  output wire        irq
);

  // ==========================================================
  // address phase capture
  reg        wr_pend_r;
  reg [7:0]  addr_r;
  wire       ph_valid;
  wire       wr_ctrl;
  wire       wr_istat;
  wire       wr_imask;

  assign ph_valid = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= ph_valid & hwrite;
      if (ph_valid) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // one decode function used by all write strobes and read mux
  function is_reg;
    input [7:0] a;
    input [7:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  assign wr_ctrl  = wr_pend_r & is_reg(addr_r, `I2CCR_OFF_CTRL);
  assign wr_istat = wr_pend_r & is_reg(addr_r, `I2CCR_OFF_IRQSTAT);
  assign wr_imask = wr_pend_r & is_reg(addr_r, `I2CCR_OFF_IRQMASK);

  // ==========================================================
  // control register
  reg  [7:0] ctrl_r;
  reg  [7:0] ctrl_nxt;
  reg  [4:0] state_r;
  wire [7:0] wmask;

  assign wmask = `I2CCR_CTRL_WMASK;

  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      // si is write-one-to-clear, other fields plain r/w
      ctrl_nxt = (hwdata[7:0] & wmask & ~(8'h01 << `I2CCR_BIT_SI)) |
                 (ctrl_r & (8'h01 << `I2CCR_BIT_SI));
      if (hwdata[`I2CCR_BIT_SI]) begin
        ctrl_nxt[`I2CCR_BIT_SI] = 1'b0;
      end
    end
    // hardware set wins over a same-cycle software clear
    if (state_load) begin
      ctrl_nxt[`I2CCR_BIT_SI] = 1'b1;
    end
    if (stop_seen && is_master) begin
      ctrl_nxt[`I2CCR_BIT_STO] = 1'b0;
    end
    if (!ctrl_nxt[`I2CCR_BIT_EN]) begin
      ctrl_nxt[`I2CCR_BIT_STO] = 1'b0;
    end
    ctrl_nxt[1:0] = 2'h0;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r  <= `I2CCR_CTRL_RST;
      state_r <= 5'h1f;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (state_load) begin
        state_r <= state_code;
      end
    end
  end

  assign controller_enable    = ctrl_r[`I2CCR_BIT_EN];
  assign start_request        = ctrl_r[`I2CCR_BIT_STA];
  assign end_transfer_request = ctrl_r[`I2CCR_BIT_STO];

  // ==========================================================
  // bus actions, gated by the enable
  // start waits for a free bus; pin routing is software's job
  assign send_start    = controller_enable & start_request & bus_free;
  assign send_stop     = controller_enable & end_transfer_request & is_master;
  // slave side: stop request drops back to not-addressed, data ignored
  assign slave_release = controller_enable & end_transfer_request & ~is_master;

  // ==========================================================
  // acknowledge drive
  i2ccr_ack_drv u_ack (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ack_assert (ctrl_r[`I2CCR_BIT_AA]),
    .byte_start (byte_start),
    .ack_slot   (ack_slot),
    .enable     (controller_enable),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe)
  );

  // ==========================================================
  // interrupt status: si event and stop-clear event, w1c
  reg  [1:0] istat_r;
  reg  [1:0] imask_r;
  wire [1:0] ev;

  assign ev = {stop_seen & is_master & end_transfer_request, state_load};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= 2'h0;
      imask_r <= `I2CCR_MASK_RST;
    end else begin
      // set beats clear in the same cycle
      istat_r <= (istat_r & ~({2{wr_istat}} & hwdata[1:0])) | ev;
      if (wr_imask) begin
        imask_r <= hwdata[1:0];
      end
    end
  end

  assign irq_ctrl = ctrl_r[`I2CCR_BIT_IE] & ctrl_r[`I2CCR_BIT_SI];
  assign irq      = |(istat_r & imask_r);

  // ==========================================================
  // read mux, registered data output
  reg [31:0] rdata_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (ph_valid && !hwrite) begin
      if (is_reg(haddr[7:0], `I2CCR_OFF_CTRL)) begin
        rdata_r <= {24'h000000, ctrl_nxt};
      end else if (is_reg(haddr[7:0], `I2CCR_OFF_STATE)) begin
        rdata_r <= {24'h000000, state_r, 3'h0};
      end else if (is_reg(haddr[7:0], `I2CCR_OFF_IRQSTAT)) begin
        rdata_r <= {30'h0, istat_r};
      end else if (is_reg(haddr[7:0], `I2CCR_OFF_IRQMASK)) begin
        rdata_r <= {30'h0, imask_r};
      end else begin
        rdata_r <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // i2ccr_ctrl

/* File: rtl/i2ccr_defs.vh */
`ifndef I2CCR_DEFS_VH
`define I2CCR_DEFS_VH

// ==========================================================
// register offsets (byte addresses)
`define I2CCR_OFF_CTRL    8'h00
`define I2CCR_OFF_STATE   8'h0c
`define I2CCR_OFF_IRQSTAT 8'h40
`define I2CCR_OFF_IRQMASK 8'h44

// ==========================================================
// control register fields
`define I2CCR_BIT_IE      7
`define I2CCR_BIT_EN      6
`define I2CCR_BIT_STA     5
`define I2CCR_BIT_STO     4
`define I2CCR_BIT_SI      3
`define I2CCR_BIT_AA      2
`define I2CCR_CTRL_WMASK  8'hf4

// ==========================================================
// reset values
`define I2CCR_CTRL_RST    8'h00
`define I2CCR_STATE_RST   8'hf8
`define I2CCR_MASK_RST    2'h0

// ==========================================================
// interrupt status layout
`define I2CCR_EV_SI       0
`define I2CCR_EV_STOP     1

// ==========================================================
// ahb encodings
`define I2CCR_HTRANS_NSQ  1'b1

`endif

/* File: rtl/i2ccr_ack_drv.v */
`timescale 1ns/100ps

// ==========================================================
// acknowledge drive: pulls data low in the ack slot when ack_assert
// was set before the byte came in; otherwise releases (nack)
module i2ccr_ack_drv (
  input  wire hclk,
  input  wire hresetn,
  input  wire ack_assert,
  input  wire byte_start,
  input  wire ack_slot,
  input  wire enable,
  output wire sda_o,
  output wire sda_oe
);
  reg ack_latched_r;

  // sample policy at byte start, so a late change does not alter this slot
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_latched_r <= 1'b0;
    end else if (byte_start) begin
      ack_latched_r <= ack_assert;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = enable & ack_slot & ack_latched_r;
endmodule // i2ccr_ack_drv

/* File: tb/i2ccr_properties.sv */
`timescale 1ns/100ps
// ==========================================================
// control output checks
module i2ccr_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        state_load,
  input wire        stop_seen,
  input wire        bus_free,
  input wire        is_master,
  input wire        ack_slot,
  input wire        controller_enable,
  input wire        start_request,
  input wire        end_transfer_request,
  input wire        send_start,
  input wire        send_stop,
  input wire        slave_release,
  input wire        sda_o,
  input wire        sda_oe,
  input wire        irq_ctrl,
  input wire        irq
);
  reg wdp_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write data phase marker: a software write lands at the edge closing it
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) wdp_r <= 1'b0;
    else wdp_r <= hsel & hready & htrans[1] & hwrite;
  property p_start; send_start == (controller_enable & start_request & bus_free); endproperty
  a_start: assert property (p_start) else $error("start issue wrong");
  property p_stop; send_stop == (controller_enable & end_transfer_request & is_master); endproperty
  a_stop: assert property (p_stop) else $error("stop issue wrong");
  property p_slv; slave_release == (controller_enable & end_transfer_request & !is_master);
  endproperty
  a_slv: assert property (p_slv) else $error("slave release wrong");
  property p_off; !controller_enable |-> !end_transfer_request; endproperty
  a_off: assert property (p_off) else $error("stop request kept while off");
  // a write in the same cycle cannot set it again, as the stop clear wins; only quiet cycles count
  property p_stoclr; stop_seen && is_master && !wdp_r |=> !end_transfer_request; endproperty
  a_stoclr: assert property (p_stoclr) else $error("stop request not cleared");
  property p_flagsw; $fell(irq_ctrl) |-> $past(wdp_r); endproperty
  a_flagsw: assert property (p_flagsw) else $error("flag dropped by itself");
  property p_irqc; $rose(irq_ctrl) |-> $past(state_load || wdp_r); endproperty
  a_irqc: assert property (p_irqc) else $error("request raised without cause");
  property p_ack; sda_oe |-> ack_slot && !sda_o; endproperty
  a_ack: assert property (p_ack) else $error("data driven outside ack slot");
endmodule // i2ccr_chk

bind i2ccr_ctrl i2ccr_chk i_chk (.*);

/* File: tb/i2ccr_peer.sv */
`timescale 1ns/100ps
// ==========================================================
// far side of the two-wire bus, seen as decoded events
module i2ccr_peer (
  input  wire       hclk,
  input  wire       sda_oe,
  output reg        state_load,
  output reg  [4:0] state_code,
  output reg        stop_seen,
  output reg        bus_free,
  output reg        is_master,
  output reg        byte_start,
  output reg        ack_slot
);
  initial {state_load, state_code, stop_seen, bus_free, is_master, byte_start, ack_slot} = 0;
  // one-cycle event: 0 new state, 1 stop seen, 2 byte begins
  task pulse(input integer k, input [4:0] c);
    begin
      @(posedge hclk);
      state_code <= c;
      if (k == 0) state_load <= 1'b1;
      else if (k == 1) stop_seen <= 1'b1;
      else byte_start <= 1'b1;
      @(posedge hclk);
      {state_load, stop_seen, byte_start} <= 3'h0;
      #1;
    end
  endtask
  // data line has a pull-up, so it reads high unless the controller drives
  task ack(output lv);
    begin
      @(posedge hclk);
      ack_slot <= 1'b1;
      @(posedge hclk);
      #1 lv = !sda_oe;
      @(posedge hclk);
      ack_slot <= 1'b0;
      #1;
    end
  endtask
endmodule // i2ccr_peer

/* File: tb/i2c_control_register_logic_bench.sv */
`timescale 1ns/100ps
`include "i2ccr_defs.vh"
module i2c_control_register_logic_bench;
  reg         hclk, hresetn, hsel, hwrite, lv;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [31:0] haddr, hwdata, rd;
  wire [31:0] hrdata;
  wire [4:0]  sc;
  wire        rdy, hresp, sl, ss, bf, im, bs, as, ce, sr, er, st, sp, rel, so, soe, ic, irq;
  integer     fail_count = 0, tests_run = 0;
  initial begin hclk = 0; forever #5 hclk = ~hclk; end
  i2ccr_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp), .state_load(sl), .state_code(sc),
    .stop_seen(ss), .bus_free(bf), .is_master(im), .byte_start(bs), .ack_slot(as),
    .controller_enable(ce), .start_request(sr), .end_transfer_request(er), .send_start(st),
    .send_stop(sp), .slave_release(rel), .sda_o(so), .sda_oe(soe), .irq_ctrl(ic), .irq(irq));
  i2ccr_peer i_peer (.hclk(hclk), .sda_oe(soe), .state_load(sl), .state_code(sc),
    .stop_seen(ss), .bus_free(bf), .is_master(im), .byte_start(bs), .ack_slot(as));
  task wrap_up;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      tests_run++;
      if (s !== e) begin fail_count++; $display("[FAIL] %0t seen %h want %h", $time, s, e); end
    end
  endtask
  // bounded wait for the slave's ready
  task wt;
    integer n;
    begin
      n = 0;
      do begin @(posedge hclk); n++; end while (rdy !== 1'b1 && n < 40);
      if (rdy !== 1'b1) begin fail_count++; wrap_up; end
    end
  endtask
  // one single word transfer; read data taken at the closing edge
  task xf(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      wt;
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      wt;
      rd = hrdata;
      #1;
    end
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    xf(0, `I2CCR_OFF_CTRL, 0); chk(rd, 0);
    chk(hresp, 0); chk(so, 0); chk(irq, 0);
    xf(0, `I2CCR_OFF_STATE, 0); chk(rd, 32'hf8);
    xf(1, `I2CCR_OFF_CTRL, 32'hffff_ff2b); xf(0, `I2CCR_OFF_CTRL, 0); chk(rd, 32'h20);
    xf(1, 32'h08, 1); xf(0, 32'h08, 0); chk(rd, 0);
    $display("reset and reserved test done");
    // pins count as routed to the bus function before this enable
    xf(1, `I2CCR_OFF_CTRL, 32'h60); chk(ce, 1); chk(st, 0);
    i_peer.bus_free <= 1'b1; #1 chk(st, 1);
    xf(1, `I2CCR_OFF_CTRL, 32'h10); xf(0, `I2CCR_OFF_CTRL, 0); chk(rd, 0);
    i_peer.is_master <= 1'b1; xf(1, `I2CCR_OFF_CTRL, 32'h50); chk(sp, 1);
    i_peer.is_master <= 1'b0; #1 chk(rel, 1);
    i_peer.is_master <= 1'b1; i_peer.pulse(1, 0); chk(er, 0);
    xf(0, `I2CCR_OFF_IRQSTAT, 0); chk(rd, 2);
    $display("start and stop test done");
    xf(1, `I2CCR_OFF_IRQSTAT, 3); xf(1, `I2CCR_OFF_IRQMASK, 3);
    xf(1, `I2CCR_OFF_CTRL, 32'hc0); i_peer.pulse(0, 5'h08); chk(ic, 1); chk(irq, 1);
    xf(0, `I2CCR_OFF_STATE, 0); chk(rd, 32'h40);
    xf(1, `I2CCR_OFF_CTRL, 32'h40); chk(ic, 0);
    xf(0, `I2CCR_OFF_CTRL, 0); chk(rd, 32'h48);
    xf(1, `I2CCR_OFF_CTRL, 32'h48); xf(0, `I2CCR_OFF_CTRL, 0); chk(rd, 32'h40);
    xf(1, `I2CCR_OFF_IRQSTAT, 3); chk(irq, 0);
    xf(1, `I2CCR_OFF_IRQMASK, 0); i_peer.pulse(0, 5'h01); chk(irq, 0);
    $display("interrupt test done");
    xf(1, `I2CCR_OFF_CTRL, 32'h44); i_peer.pulse(2, 0); i_peer.ack(lv); chk(lv, 0);
    xf(1, `I2CCR_OFF_CTRL, 32'h40); i_peer.pulse(2, 0); i_peer.ack(lv); chk(lv, 1);
    $display("acknowledge test done");
    // mid-run reset: control and state registers and both interrupt outputs back to reset values
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    xf(0, `I2CCR_OFF_CTRL, 0); chk(rd, 0);
    xf(0, `I2CCR_OFF_STATE, 0); chk(rd, 32'hf8);
    chk(ic, 0); chk(irq, 0);
    $display("second reset test done");
    wrap_up;
  end
endmodule // i2c_control_register_logic_bench
